// ### rtl/fault_response_map.vh
// constants for the fault response and display logic
`ifndef FAULT_RESPONSE_MAP_VH
`define FAULT_RESPONSE_MAP_VH
// =========================================
// display codes
`define CODE_NONE            4'h0
`define CODE_INPUT_FAULT     4'h1
`define CODE_MEMORY_FAULT    4'h2
`define CODE_CONVERTER_FAULT 4'h3
`define CODE_CAL_FAULT       4'h4
`define CODE_UNDER_RANGE     4'h5
`define CODE_OVER_RANGE      4'h6
`define CODE_GENERIC_FAULT   4'h7
// =========================================
// display range limits, signed 16 bit
`define RANGE_LOW            16'hf831
`define RANGE_HIGH           16'h270f
// =========================================
// output level when forced off (0 percent)
`define OUT_OFF_LEVEL        12'h000
// =========================================
// timing
`define CLOCK_HZ             125000000
`define CAL_SHOW_MS          2000
`define CAL_SHOW_CYCLES      (`CLOCK_HZ / 1000 * `CAL_SHOW_MS)
`define BLINK_MS             500
`define BLINK_CYCLES         (`CLOCK_HZ / 1000 * `BLINK_MS)
`endif

// ### rtl/sync_bit.v
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module sync_bit (
    input  wire clock,
    input  wire resetn,
    input  wire din,
    output reg  dout
);
    reg stage1; // first stage, read only by dout
    // =========================================
    // two-stage capture
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // sync_bit

// ### rtl/fault_response.v
// fault response and front-panel error display logic
// Function
// - alternate primary display: fault code, selected item
// - input fault: control outputs take substitute value
// - input fault: alarms act as upper exceeded
// - input fault: program keeps running
// - memory fault: alarms off, control at 0%
// - converter fault: outputs off, program halted
// - calibration fault checked for temperature; shown 2s
// - calibration fault: outputs keep operating normally
// - show over-range below -1999 or above 9999 when control range is wider
// - over-range is no fault; control continues
// - motor calibration failure: generic code, secondary display
// - fault output 1 follows input fault
// - fault output 2 follows converter fault
`timescale 1ns/10ps
`include "fault_response_map.vh"
module fault_response #(
    parameter CAL_SHOW_CYCLES = `CAL_SHOW_CYCLES, // calibration code show time
    parameter BLINK_CYCLES    = `BLINK_CYCLES,    // display alternation half period
    parameter ALARMS          = 2,                // number of alarm outputs
    parameter OUT_W           = 12                // control output width
) (
    input  wire                clock,
    input  wire                resetn,
    input  wire                input_fault_pin,
    input  wire                memory_fault_pin,
    input  wire                converter_fault_pin,
    input  wire                cal_fault_pin,
    input  wire                motor_cal_fail_pin,
    input  wire                temperature_input,
    input  wire                control_range_wider,
    input  wire signed [15:0]  measured_value,
    input  wire [3:0]          selected_item,
    input  wire [OUT_W-1:0]    manipulated_value,
    input  wire [OUT_W-1:0]    substitute_value,
    input  wire [ALARMS-1:0]   alarm_normal,
    input  wire [ALARMS-1:0]   alarm_upper,
    input  wire                program_run_request,
    input  wire                aux1_is_fault1,
    input  wire                aux2_is_fault2,
    output reg  [3:0]          primary_display,
    output reg                 primary_is_code,
    output reg  [3:0]          secondary_code,
    output reg                 secondary_is_code,
    output reg  [OUT_W-1:0]    control_out,
    output reg  [ALARMS-1:0]   alarm_out,
    output reg                 program_run,
    output reg                 aux_out1,
    output reg                 aux_out2,
    output reg                 over_range
);
    // =========================================
    // synchronised fault inputs
    // every pin and selection level below comes from outside this
    // clock domain, so each passes two flip-flops before any logic
    wire input_fault;      // live input fault
    wire memory_raw;       // memory fault before latch
    wire converter_raw;    // converter fault before latch
    wire cal_raw;          // calibration data fault
    wire motor_fail;       // motor calibration failure
    wire temp_sel;         // temperature input type selected
    wire range_wider;      // control range wider than display

    // input fault level
    sync_bit u_s0 (
        .clock  (clock),
        .resetn (resetn),
        .din    (input_fault_pin),
        .dout   (input_fault)
    );
    // memory fault level
    sync_bit u_s1 (
        .clock  (clock),
        .resetn (resetn),
        .din    (memory_fault_pin),
        .dout   (memory_raw)
    );
    // converter fault level
    sync_bit u_s2 (
        .clock  (clock),
        .resetn (resetn),
        .din    (converter_fault_pin),
        .dout   (converter_raw)
    );
    // calibration data fault level
    sync_bit u_s3 (
        .clock  (clock),
        .resetn (resetn),
        .din    (cal_fault_pin),
        .dout   (cal_raw)
    );
    // motor calibration failure level
    sync_bit u_s4 (
        .clock  (clock),
        .resetn (resetn),
        .din    (motor_cal_fail_pin),
        .dout   (motor_fail)
    );
    // temperature input type selection
    sync_bit u_s5 (
        .clock  (clock),
        .resetn (resetn),
        .din    (temperature_input),
        .dout   (temp_sel)
    );
    // control range wider than display range
    sync_bit u_s6 (
        .clock  (clock),
        .resetn (resetn),
        .din    (control_range_wider),
        .dout   (range_wider)
    );

    // =========================================
    // latched faults
    reg memory_latched;    // memory fault held to reset
    reg converter_latched; // converter fault held to reset

    // latch until power-on reset
    // the pin may drop back at once; the latch keeps the outputs
    // forced off so the fault stays visible until power cycles
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            memory_latched    <= 1'b0;
            converter_latched <= 1'b0;
        end else begin
            if (memory_raw)
                memory_latched <= 1'b1;
            if (converter_raw)
                converter_latched <= 1'b1;
        end
    end

    wire memory_fault    = memory_raw | memory_latched;
    wire converter_fault = converter_raw | converter_latched;
    wire hard_fault      = memory_fault | converter_fault;    // forced-off condition

    // =========================================
    // calibration code window after power-up
    reg [31:0] cal_timer;  // cycles since release of reset
    reg        cal_window; // calibration code shown while high

    // two-second window from reset release
    // the counter stops once the window closes, so it never wraps
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cal_timer  <= 32'h00000000;
            cal_window <= 1'b1;
        end else if (cal_window) begin
            if (cal_timer >= CAL_SHOW_CYCLES - 1)
                cal_window <= 1'b0;
            cal_timer <= cal_timer + 32'h00000001;
        end
    end

    wire cal_shown = cal_window & temp_sel & cal_raw;

    // =========================================
    // display range check
    // limits are signed; only used when the control range is wider
    wire under = (measured_value < $signed(`RANGE_LOW));
    wire over  = (measured_value > $signed(`RANGE_HIGH));
    wire range_out = range_wider & (under | over);

    // =========================================
    // alternation timer
    reg [31:0] blink_count; // half-period counter
    reg        blink_phase; // high shows fault code

    // free-running toggle
    // runs whether or not a fault is active; a new fault may
    // first show the selected item for up to one half period
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            blink_count <= 32'h00000000;
            blink_phase <= 1'b0;
        end else if (blink_count >= BLINK_CYCLES - 1) begin
            blink_count <= 32'h00000000;
            blink_phase <= ~blink_phase;
        end else begin
            blink_count <= blink_count + 32'h00000001;
        end
    end

    // =========================================
    // active fault code, highest priority first
    // hard faults outrank the live input fault, which outranks
    // the calibration code and the over-range indicator
    reg [3:0] fault_code; // code of the shown fault
    reg       fault_any;  // some fault or indicator active

    always @* begin
        fault_code = `CODE_NONE;
        fault_any  = 1'b1;
        if (memory_fault) begin
            fault_code = `CODE_MEMORY_FAULT;
        end else if (converter_fault) begin
            fault_code = `CODE_CONVERTER_FAULT;
        end else if (input_fault) begin
            fault_code = `CODE_INPUT_FAULT;
        end else if (cal_shown) begin
            fault_code = `CODE_CAL_FAULT;
        end else if (range_out) begin
            fault_code = under ? `CODE_UNDER_RANGE : `CODE_OVER_RANGE;
        end else begin
            fault_any = 1'b0;
        end
    end

    // =========================================
    // next output values
    // forcing follows the most restrictive active fault
    reg [OUT_W-1:0]  next_control; // control output value
    reg [ALARMS-1:0] next_alarm;   // alarm output value
    reg              next_run;     // program run state

    always @* begin
        next_control = manipulated_value;
        next_alarm   = alarm_normal;
        next_run     = program_run_request;
        if (hard_fault) begin
            next_control = `OUT_OFF_LEVEL;
            next_alarm   = {ALARMS{1'b0}};
            if (converter_fault)
                next_run = 1'b0;
        end else if (input_fault) begin
            next_control = substitute_value;
            next_alarm   = alarm_upper;
        end
    end

    // =========================================
    // primary display: fault code and selected item in turn
    // the code shows only in the high blink phase, so the
    // operator still sees the selected item half the time
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            primary_display <= 4'h0; // blank during reset
            primary_is_code <= 1'b0;
        end else if (fault_any && blink_phase) begin
            primary_display <= fault_code;
            primary_is_code <= 1'b1;
        end else begin
            primary_display <= selected_item; // item phase or no fault
            primary_is_code <= 1'b0;
        end
    end

    // =========================================
    // secondary display: generic code on motor calibration failure
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            secondary_code    <= `CODE_NONE;
            secondary_is_code <= 1'b0;
        end else if (motor_fail) begin
            secondary_code    <= `CODE_GENERIC_FAULT;
            secondary_is_code <= 1'b1;
        end else begin
            secondary_code    <= `CODE_NONE; // no failure
            secondary_is_code <= 1'b0;
        end
    end

    // =========================================
    // control, alarm and program run outputs
    // the off level is also the reset value, so the output
    // stage never sees a stray level while power comes up
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            control_out <= `OUT_OFF_LEVEL;
            alarm_out   <= {ALARMS{1'b0}};
            program_run <= 1'b0;
        end else begin
            control_out <= next_control;
            alarm_out   <= next_alarm;
            program_run <= next_run;
        end
    end

    // =========================================
    // fault outputs routed to the auxiliary outputs
    // the assignment bits are configuration on this clock, so
    // they are read without synchronisers
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aux_out1 <= 1'b0;
            aux_out2 <= 1'b0;
        end else begin
            aux_out1 <= aux1_is_fault1 & input_fault;
            aux_out2 <= aux2_is_fault2 & converter_fault;
        end
    end

    // =========================================
    // over-range indicator, apart from the fault forcing
    // it is no fault, so it never touches control or alarms
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            over_range <= 1'b0;
        end else begin
            over_range <= range_out;
        end
    end
endmodule // fault_response

// ### sim/front_end_model.sv
// model of the measurement front end and the output stage data
`timescale 1ns/10ps
module front_end_model (
    output reg signed [15:0] measured_value,    // measured value
    output reg        [11:0] manipulated_value, // normal control value
    output reg        [11:0] substitute_value,  // value used on input fault
    output reg        [1:0]  alarm_normal,      // normal alarm states
    output reg        [1:0]  alarm_upper        // alarm states as if upper exceeded
);
    integer    seed = 9871; // fixed seed
    reg [31:0] r;           // raw random word
    // =========================================
    // fresh values, called by the bench at a falling edge
    task roll;
        begin
            r = $random(seed);
            measured_value = r[15:0];
            manipulated_value = r[27:16];
            r = $random(seed);
            substitute_value = r[11:0];
            alarm_normal = r[13:12];
            alarm_upper = r[15:14];
        end
    endtask
    initial roll;
endmodule // front_end_model

// ### sim/fault_response_asserts.sv
// port assertions for the fault response block
`timescale 1ns/10ps
module fault_response_asserts #(
    parameter CAL_SHOW_CYCLES = 25, // calibration code show time
    parameter ALARMS          = 2,  // number of alarm outputs
    parameter OUT_W           = 12  // control output width
) (
    input wire                clock,
    input wire                resetn,
    input wire                input_fault_pin,
    input wire                memory_fault_pin,
    input wire                converter_fault_pin,
    input wire                cal_fault_pin,
    input wire                temperature_input,
    input wire                control_range_wider,
    input wire signed [15:0]  measured_value,
    input wire [3:0]          selected_item,
    input wire [OUT_W-1:0]    manipulated_value,
    input wire [OUT_W-1:0]    substitute_value,
    input wire [ALARMS-1:0]   alarm_normal,
    input wire [ALARMS-1:0]   alarm_upper,
    input wire                program_run_request,
    input wire                aux1_is_fault1,
    input wire                aux2_is_fault2,
    input wire [3:0]          primary_display,
    input wire                primary_is_code,
    input wire [OUT_W-1:0]    control_out,
    input wire [ALARMS-1:0]   alarm_out,
    input wire                program_run,
    input wire                aux_out1,
    input wire                aux_out2,
    input wire                over_range
);
    reg        hard;     // a memory or converter pin was seen since reset
    reg [31:0] up_count; // edges since reset release, saturating
    wire       cal_only = cal_fault_pin && temperature_input && !input_fault_pin && !hard
                          && !memory_fault_pin && !converter_fault_pin
                          && up_count < CAL_SHOW_CYCLES - 8; // lone calibration fault, window open
    // =========================================
    // helper: sticky record of hard faults
    always @(posedge clock or negedge resetn) begin
        if (!resetn) hard <= 1'b0;
        else if (memory_fault_pin | converter_fault_pin) hard <= 1'b1;
    end
    // helper: edges since reset release, held at the top
    always @(posedge clock or negedge resetn) begin
        if (!resetn) up_count <= 32'h00000000;
        else if (up_count != 32'hffffffff) up_count <= up_count + 32'h00000001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence mem_seen; memory_fault_pin[*3]; endsequence
    sequence conv_seen; converter_fault_pin[*3]; endsequence
    sequence cal_start; !cal_only ##1 cal_only[*4]; endsequence
    sequence calm; (!input_fault_pin && !hard && !memory_fault_pin && !converter_fault_pin)[*3];
    endsequence
    sequence inp_seen; (input_fault_pin && !hard && !memory_fault_pin && !converter_fault_pin)[*3];
    endsequence
    mem_off_a: assert property (mem_seen |=> control_out == 0 && alarm_out == 0)
        else $error("memory fault outputs not off");
    conv_halt_a: assert property (conv_seen |=>
        control_out == 0 && alarm_out == 0 && !program_run)
        else $error("converter fault outputs not off");
    mem_latch_a: assert property (mem_seen ##1 !memory_fault_pin[*3] |-> alarm_out == 0)
        else $error("memory fault not held");
    inp_sub_a: assert property (inp_seen |=> control_out == $past(substitute_value)
        && alarm_out == $past(alarm_upper) && program_run == $past(program_run_request))
        else $error("input fault response wrong");
    calm_run_a: assert property (calm |=> control_out == $past(manipulated_value)
        && alarm_out == $past(alarm_normal)) else $error("normal outputs wrong");
    aux_one_a: assert property ((input_fault_pin && aux1_is_fault1)[*3] |=> aux_out1)
        else $error("fault output 1 missing");
    aux_two_a: assert property ((converter_fault_pin && aux2_is_fault2)[*3] |=> aux_out2)
        else $error("fault output 2 missing");
    over_hi_a: assert property (control_range_wider[*3] ##0 measured_value > 16'sd9999
        |=> over_range) else $error("over-range not shown");
    range_off_a: assert property (!control_range_wider[*3] |=> !over_range)
        else $error("over-range shown when narrow");
    item_show_a: assert property (!primary_is_code && $past(resetn)
        |-> primary_display == $past(selected_item)) else $error("selected item not shown");
    mem_code_a: assert property (mem_seen |-> ##[1:4]
        (primary_is_code && primary_display == 4'h2)) else $error("memory fault code not shown");
    cal_code_a: assert property (cal_start |-> ##[0:3]
        (primary_is_code && primary_display == 4'h4)) else $error("calibration code not shown");
    cal_late_a: assert property (up_count > CAL_SHOW_CYCLES |->
        !(primary_is_code && primary_display == 4'h4)) else $error("calibration code too late");
endmodule // fault_response_asserts

// ### sim/testbench.sv
// self-checking bench for the fault response block
`timescale 1ns/10ps
module testbench;
    reg clock = 0, resetn = 0, hard_mem = 0, hard_conv = 0;
    reg input_fault_pin = 0, memory_fault_pin = 0, converter_fault_pin = 0, cal_fault_pin = 0;
    reg motor_cal_fail_pin = 0, temperature_input = 0, control_range_wider = 0;
    reg aux1_is_fault1 = 0, aux2_is_fault2 = 0, program_run_request = 0;
    reg [3:0] selected_item = 4'h9; // item shown between codes
    wire signed [15:0] measured_value;
    wire [11:0] manipulated_value, substitute_value, control_out;
    wire [1:0] alarm_normal, alarm_upper, alarm_out;
    wire [3:0] primary_display, secondary_code;
    wire primary_is_code, secondary_is_code, program_run, aux_out1, aux_out2, over_range;
    wire [22:0] obs = {program_run, aux_out1, aux_out2, over_range, alarm_out, control_out,
                       secondary_is_code, secondary_code}; // observed result
    reg [22:0] exp_q[$]; // expected results
    event look;          // a result is due
    integer fail_count = 0, n_compared = 0, cycles = 0;
    front_end_model i_front_end_model (.measured_value, .manipulated_value,
        .substitute_value, .alarm_normal, .alarm_upper);
    fault_response #(.CAL_SHOW_CYCLES(25), .BLINK_CYCLES(2)) i_fault_response (.clock, .resetn,
        .input_fault_pin, .memory_fault_pin, .converter_fault_pin, .cal_fault_pin,
        .motor_cal_fail_pin, .temperature_input, .control_range_wider, .measured_value,
        .selected_item, .manipulated_value, .substitute_value, .alarm_normal, .alarm_upper,
        .program_run_request, .aux1_is_fault1, .aux2_is_fault2, .primary_display,
        .primary_is_code, .secondary_code, .secondary_is_code, .control_out, .alarm_out,
        .program_run, .aux_out1, .aux_out2, .over_range);
    initial forever #4 clock = ~clock;
    // =========================================
    // compare and report
    task check(input [22:0] seen, input [22:0] want);
        begin
            n_compared = n_compared + 1;
            if (seen !== want) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: %h vs %h", $time, seen, want);
            end
        end
    endtask
    task end_sim;
        begin
            if (fail_count == 0 && n_compared > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // drive all condition inputs at once
    task drive(input [9:0] s);
        {input_fault_pin, memory_fault_pin, converter_fault_pin, cal_fault_pin, motor_cal_fail_pin,
         temperature_input, control_range_wider, aux1_is_fault1, aux2_is_fault2,
         program_run_request} = s;
    endtask
    task do_reset;
        begin
            drive(10'h000);
            resetn = 0;
            hard_mem = 0;
            hard_conv = 0;
            repeat (5) @(negedge clock);
            resetn = 1;
        end
    endtask
    // apply one condition set, then note the expected result
    task apply(input [9:0] s);
        reg hard;
        begin
            @(negedge clock);
            drive(s);
            i_front_end_model.roll;
            selected_item = selected_item + 4'h3; // new item each step
            hard_mem = hard_mem | memory_fault_pin;
            hard_conv = hard_conv | converter_fault_pin;
            hard = hard_mem | hard_conv;
            repeat (4) @(negedge clock);
            exp_q.push_back({!hard_conv & program_run_request, input_fault_pin & aux1_is_fault1,
                hard_conv & aux2_is_fault2, control_range_wider & (measured_value < -16'sd1999
                | measured_value > 16'sd9999), hard ? 2'h0 : input_fault_pin ? alarm_upper :
                alarm_normal, hard ? 12'h000 : input_fault_pin ? substitute_value :
                manipulated_value, motor_cal_fail_pin, motor_cal_fail_pin ? 4'h7 : 4'h0});
            -> look;
        end
    endtask
    // watcher: oldest note against the outputs
    initial forever begin
        @(look);
        check(obs, exp_q.pop_front());
    end
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            fail_count = fail_count + 1;
            end_sim;
        end
    end
    // =========================================
    // main sequence: normal, faults, latches, second reset
    initial begin
        do_reset;
        repeat (2) apply(10'b0000001001);
        apply(10'b0001011001);
        apply(10'b1000001111);
        apply(10'b1000100001);
        apply(10'b0001011001);
        apply(10'b0010001011);
        apply(10'b1000000011);
        do_reset;
        apply(10'b0100001000);
        apply(10'b0000001000);
        end_sim;
    end
endmodule // testbench
bind fault_response fault_response_asserts #(.CAL_SHOW_CYCLES(CAL_SHOW_CYCLES), .ALARMS(ALARMS),
    .OUT_W(OUT_W)) i_asserts (
    .clock, .resetn, .input_fault_pin, .memory_fault_pin, .converter_fault_pin,
    .cal_fault_pin, .temperature_input, .control_range_wider, .measured_value, .selected_item,
    .manipulated_value, .substitute_value, .alarm_normal, .alarm_upper, .program_run_request,
    .aux1_is_fault1, .aux2_is_fault2, .primary_display, .primary_is_code,
    .control_out, .alarm_out, .program_run, .aux_out1, .aux_out2, .over_range);
